// ==== bench/flash_fe_checker.sv ====
// Concurrent checks on the serial flash command front end ports.
// Assumes a bind onto the top module; SPI pins reach it through a synchroniser.
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_defs.vh"
module flash_fe_checker (
  input wire logic               clk_sys_i,
  input wire logic               rst_n_i,
  input wire logic               cs_n_i,
  input wire logic               sck_i,
  input wire logic               so_o,
  input wire logic               so_oe_n_o,
  input wire logic [`ADDR_W-1:0] mem_addr_o,
  input wire logic               mem_rd_o,
  input wire logic               cmd_stb_o,
  input wire logic [7:0]         cmd_op_o,
  input wire logic               wr_stb_o,
  input wire logic               seq_mode_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // Windows allow for the two-flop pin synchroniser lag
  a_stb_pulse: assert property (cmd_stb_o |=> !cmd_stb_o)
    else $error("command strobe longer than a cycle");
  a_stb_after_cs: assert property (cmd_stb_o |-> $past(cs_n_i, 2))
    else $error("command strobe inside a frame");
  a_op_hold: assert property (!cmd_stb_o |-> $stable(cmd_op_o))
    else $error("opcode changed without strobe");
  a_wr_in_frame: assert property (wr_stb_o |-> !$past(cs_n_i, 4))
    else $error("write strobe outside a frame");
  a_oe_release: assert property ($rose(cs_n_i) |-> ##[1:6] so_oe_n_o)
    else $error("serial output not released");
  a_addr_step: assert property (mem_rd_o && $past(mem_rd_o) && $changed(mem_addr_o)
    |-> mem_addr_o == $past(mem_addr_o) + 1'b1)
    else $error("read address did not step by one");
  a_no_read_stb: assert property (cmd_stb_o |-> !(cmd_op_o inside {8'h0B, 8'h03}))
    else $error("read frame gave a strobe");
  // Output may only move after a falling serial clock
  a_so_on_fall: assert property (!so_oe_n_o && $changed(so_o) |-> !$past(sck_i, 2))
    else $error("serial output moved off a falling edge");
  a_seq_entry: assert property ($rose(seq_mode_o) |-> cmd_op_o inside {8'hAD, 8'hAF})
    else $error("sequential mode without its opcode");
  c_strobe: cover property (cmd_stb_o);
  c_seq_write: cover property (wr_stb_o && seq_mode_o);
  c_drive: cover property ($fell(so_oe_n_o));
endmodule
bind serial_flash_command_front_end flash_fe_checker chk (
  .clk_sys_i(clk_sys_i),
  .rst_n_i(rst_n_i),
  .cs_n_i(cs_n_i),
  .sck_i(sck_i),
  .so_o(so_o),
  .so_oe_n_o(so_oe_n_o),
  .mem_addr_o(mem_addr_o),
  .mem_rd_o(mem_rd_o),
  .cmd_stb_o(cmd_stb_o),
  .cmd_op_o(cmd_op_o),
  .wr_stb_o(wr_stb_o),
  .seq_mode_o(seq_mode_o)
);
`default_nettype wire

// ==== bench/serial_flash_command_front_end_tb.sv ====
// Self-checking bench for the serial flash command front end.
// Assumes spi_host_model drives the SPI pins; the bench models the array.
`timescale 1ns/1ps
`default_nettype none
module serial_flash_command_front_end_tb;
  localparam logic [31:0] ID_VAL = 32'h1234_5678; // Arbitrary identification value
  localparam logic [7:0]  STAT   = 8'hA5;
  localparam logic [7:0]  PROT   = 8'h5B;
  logic        clk_sys_i, rst_n_i, cs_n, sck, si, so, so_oe_n, mem_rd, cmd_stb, wr_stb, seq_md;
  logic [19:0] mem_addr, cmd_addr, wr_addr, l_adr;
  logic [19:0] wa [0:7];
  logic [7:0]  cmd_op, wr_data, l_op;
  logic [7:0]  wd [0:7];
  logic [7:0]  mem_data = 8'h00;
  logic [8:0]  cmd_cnt, l_cnt;
  int          err_total = 0, checks_done = 0, n_stb = 0, n_wr = 0, cyc = 0;
  wire logic   so_line = so_oe_n ? 1'bz : so; // Floats unless driven
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  serial_flash_command_front_end #(.ID_WORD(ID_VAL)) dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
    .so_o(so), .so_oe_n_o(so_oe_n), .mem_addr_o(mem_addr), .mem_rd_o(mem_rd),
    .mem_data_i(mem_data), .status_i(STAT), .prot_i(PROT), .cmd_stb_o(cmd_stb),
    .cmd_op_o(cmd_op), .cmd_addr_o(cmd_addr), .cmd_cnt_o(cmd_cnt), .wr_stb_o(wr_stb),
    .wr_data_o(wr_data), .wr_addr_o(wr_addr), .seq_mode_o(seq_md));
  spi_host_model host (.cs_n_o(cs_n), .sck_o(sck), .si_o(si), .so_i(so_line));
  function automatic logic [7:0] pat(input logic [19:0] a);
    return a[7:0] + a[19:12] + 8'h21;
  endfunction
  // Array answers one clock after the address
  always @(posedge clk_sys_i) begin
    mem_data <= #1 pat(mem_addr);
    if (cmd_stb) begin
      n_stb++;
      l_op = cmd_op;
      l_adr = cmd_addr;
      l_cnt = cmd_cnt;
    end
    if (wr_stb) begin
      wa[n_wr%8] = wr_addr;
      wd[n_wr%8] = wr_data;
      n_wr++;
    end
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      $display("ERROR timeout expected 0 seen %0d", cyc);
      conclude;
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic frame(input logic [63:0] b, input int nbits, input bit m3);
    for (int i = 0; i < 8; i++) host.tx[i] = b[63-8*i -: 8];
    n_stb = 0;
    n_wr = 0;
    host.xfer(nbits, m3);
  endtask
  task automatic t_read_wrap;
    frame({8'h03, 24'hFF_FFFF, 32'h0}, 51, 1'b0);
    chk("rd_last", pat(20'hF_FFFF), host.rx[4]);
    chk("rd_wrap", pat(20'h0_0000), host.rx[5]);
    chk("rd_oe", 1, so_oe_n);
    chk("rd_mrd", 0, mem_rd);
    chk("rd_adr", 20'h0_0002, mem_addr);
    chk("rd_stb", 0, n_stb);
    $display("test read_wrap done");
  endtask
  task automatic t_fast_read;
    frame({8'h0B, 24'hF0_0010, 8'h77, 24'h0}, 56, 1'b1);
    chk("fr_b0", pat(20'h0_0010), host.rx[5]);
    chk("fr_b1", pat(20'h0_0011), host.rx[6]);
    $display("test fast_read done");
  endtask
  task automatic t_cmd_table;
    logic [7:0] ops [0:10];
    ops = '{8'h20, 8'h52, 8'hD8, 8'h36, 8'h39, 8'h60, 8'hC7, 8'h06, 8'h04, 8'hB9, 8'hAB};
    for (int k = 0; k < 11; k++) begin
      frame({ops[k], 24'hFA_BCDE, 32'h0}, (k < 5) ? 32 : 8, k[0]);
      chk("tb_stb", 1, n_stb);
      chk("tb_op", ops[k], l_op);
      chk("tb_cnt", 0, l_cnt);
      if (k < 5) chk("tb_adr", 20'hA_BCDE, l_adr);
    end
    $display("test cmd_table done");
  endtask
  task automatic t_page_prog;
    frame({8'h02, 24'h00_00FE, 24'h11_2233, 8'h0}, 56, 1'b0);
    chk("pp_n", 3, n_wr);
    for (int i = 0; i < 3; i++) begin
      chk("pp_adr", {12'h000, 8'hFE + i[7:0]}, wa[i]);
      chk("pp_dat", 8'h11 * (i + 1), wd[i]);
    end
    chk("pp_cnt", 3, l_cnt);
    $display("test page_prog done");
  endtask
  task automatic t_seq_prog;
    frame({8'hAD, 24'h00_0100, 8'h44, 24'h0}, 40, 1'b0);
    chk("sq_adr0", 20'h0_0100, wa[0]);
    chk("sq_mode", 1, seq_md);
    frame({8'hAF, 8'h55, 48'h0}, 16, 1'b1);
    chk("sq_adr1", 20'h0_0101, wa[0]);
    chk("sq_dat1", 8'h55, wd[0]);
    frame({8'h04, 56'h0}, 8, 1'b0);
    chk("sq_exit", 0, seq_md);
    $display("test seq_prog done");
  endtask
  task automatic t_refuse;
    frame({8'hFF, 24'h06_0606, 32'h0}, 32, 1'b0);
    chk("bad_op", 0, n_stb);
    frame({8'h20, 16'h0102, 40'h0}, 24, 1'b1);
    chk("short_adr", 0, n_stb);
    frame({8'h02, 24'h0, 8'h11, 24'h0}, 43, 1'b0);
    chk("part_byte", 0, n_stb);
    $display("test refuse done");
  endtask
  task automatic t_status_id;
    frame({8'h05, 56'h0}, 24, 1'b0);
    chk("st_b0", STAT, host.rx[1]);
    chk("st_b1", STAT, host.rx[2]);
    frame({8'h9F, 56'h0}, 40, 1'b1);
    for (int i = 0; i < 4; i++) chk("id_b", ID_VAL[31-8*i -: 8], host.rx[i+1]);
    frame({8'h3C, 56'h0}, 40, 1'b0);
    chk("prot_b", PROT, host.rx[4]);
    frame({8'h01, 8'h5A, 48'h0}, 16, 1'b0);
    chk("ws_dat", 8'h5A, wd[0]);
    chk("ws_cnt", 1, l_cnt);
    $display("test status_id done");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Reset held for 12 clocks, then every scenario in turn
  initial begin
    rst_n_i = 1'b0;
    repeat (12) @(posedge clk_sys_i);
    #1 rst_n_i = 1'b1;
    repeat (4) @(posedge clk_sys_i);
    // Link steps are whole ns from here, so pins never move on a rising clock edge
    #1.5;
    t_read_wrap;
    t_fast_read;
    t_cmd_table;
    t_page_prog;
    t_seq_prog;
    t_refuse;
    t_status_id;
    conclude;
  end
endmodule
`default_nettype wire

// ==== bench/spi_host_model.sv ====
// Behavioural SPI master that frames one transfer per call.
// Assumes the bench loads tx before a call and reads rx after it.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  output logic      cs_n_o,
  output logic      sck_o,
  output logic      si_o,
  input wire logic  so_i
);
  logic [7:0] tx [0:7];
  logic [7:0] rx [0:7];
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
  end
  // Clock idles low or high; 32 ns half period, stands still outside frames
  task automatic xfer(input int nbits, input bit idle_hi);
    sck_o = idle_hi;
    #40 cs_n_o = 1'b0;
    #32;
    for (int i = 0; i < nbits; i++) begin
      sck_o = 1'b0;
      si_o = tx[i/8][7-i%8];
      #32 sck_o = 1'b1;
      rx[i/8][7-i%8] = so_i;
      #32;
    end
    sck_o = idle_hi;
    #32 cs_n_o = 1'b1;
    si_o = ~si_o; // Released line must not keep its last value
    #40;
  endtask
endmodule
`default_nettype wire

// ==== design/flash_cmd_defs.vh ====
// Constants for the serial flash command front end.
// Assumes inclusion by bare name from files under design/.
`ifndef FLASH_CMD_DEFS_VH
`define FLASH_CMD_DEFS_VH

// Widths
`define ADDR_W        20
`define CNT_W         9
`define PAGE_BYTES    9'h100
`define ID_BYTES      9'h004
`define ADDR_BYTES_M1 2'h2

// Opcodes
`define OP_READ_FAST  8'h0B
`define OP_READ_SLOW  8'h03
`define OP_ERASE_4K   8'h20
`define OP_ERASE_32K  8'h52
`define OP_ERASE_64K  8'hD8
`define OP_CHIP_ER_A  8'h60
`define OP_CHIP_ER_B  8'hC7
`define OP_PROG_PAGE  8'h02
`define OP_PROG_SEQ_A 8'hAD
`define OP_PROG_SEQ_B 8'hAF
`define OP_WRITE_EN   8'h06
`define OP_WRITE_DIS  8'h04
`define OP_PROT_SECT  8'h36
`define OP_UNPROT_SEC 8'h39
`define OP_READ_PROT  8'h3C
`define OP_READ_STAT  8'h05
`define OP_WRITE_STAT 8'h01
`define OP_READ_ID    8'h9F
`define OP_PWR_DOWN   8'hB9
`define OP_PWR_RESUME 8'hAB

// Opcode class: [4] valid [3] address [2] dummy [1] data in [0] data out
`define CL_VALID      4
`define CL_ADDR       3
`define CL_DUMMY      2
`define CL_DIN        1
`define CL_DOUT       0
`define CLS_RD_FAST   5'h1D
`define CLS_RD_ADDR   5'h19
`define CLS_ADDR_ONLY 5'h18
`define CLS_ADDR_DIN  5'h1A
`define CLS_DIN_ONLY  5'h12
`define CLS_DOUT_ONLY 5'h11
`define CLS_BARE      5'h10
`define CLS_INVALID   5'h00

// Reset values
`define RST_ID_WORD   32'h5A5A_0000

`endif

// ==== design/pin_sync.v ====
// Two-flop synchroniser for a group of pin inputs.
// Assumes each bit is an independent level from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter             WIDTH   = 3,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
)(
  input  wire             clk_sys_i,
  input  wire             rst_n_i,
  input  wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] meta_ff;
  reg [WIDTH-1:0] sync_ff;

  // First stage feeds only the second stage
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;
endmodule
`default_nettype wire

// ==== design/serial_flash_command_front_end.v ====
// Serial flash command front end: SPI slave framing, opcode decode,
// address and dummy collection, data capture and streamed read output.
// Assumes the SPI pins are asynchronous to clk_sys_i and toggle well below
// a sixth of its rate; array data follows mem_addr_o after one clock.
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_defs.vh"

// Operation
// - Modes 0/3: sample rising, drive falling
// - All bytes shifted most significant bit first
// - Chip select release ends operation, back idle
// - Unknown opcode ignored until next frame
// - Early release before address completes does nothing
// - Three address bytes, top four bits dropped
// - Fast read: address, dummy byte, stream
// - Slow read: address then stream, no dummy
// - Block erases take address; chip erases none
// - Page program: address, 1 to 256 bytes
// - Sequential program: address first, then counter
// - Protection read: address then output bytes
// - Status read repeats; status write one byte
// - Identification returns up to four bytes
// - Power-down enter and resume, bare opcodes
// - Read address advances automatically per byte
// - Address wraps from top to zero seamlessly
// - Release during read ends it, output floats
module serial_flash_command_front_end #(
  parameter [31:0] ID_WORD = `RST_ID_WORD  // Arbitrary identification value
)(
  input  wire              clk_sys_i,
  input  wire              rst_n_i,
  input  wire              cs_n_i,
  input  wire              sck_i,
  input  wire              si_i,
  output reg               so_o,
  output reg               so_oe_n_o,
  output reg  [`ADDR_W-1:0] mem_addr_o,
  output reg               mem_rd_o,
  input  wire [7:0]        mem_data_i,
  input  wire [7:0]        status_i,
  input  wire [7:0]        prot_i,
  output reg               cmd_stb_o,
  output reg  [7:0]        cmd_op_o,
  output reg  [`ADDR_W-1:0] cmd_addr_o,
  output reg  [`CNT_W-1:0] cmd_cnt_o,
  output reg               wr_stb_o,
  output reg  [7:0]        wr_data_o,
  output reg  [`ADDR_W-1:0] wr_addr_o,
  output reg               seq_mode_o
);

  // One-hot frame states
  localparam [6:0] ST_OPC   = 7'h01;
  localparam [6:0] ST_ADDR  = 7'h02;
  localparam [6:0] ST_DUMMY = 7'h04;
  localparam [6:0] ST_DIN   = 7'h08;
  localparam [6:0] ST_DOUT  = 7'h10;
  localparam [6:0] ST_DONE  = 7'h20;
  localparam [6:0] ST_IGN   = 7'h40;

  wire [2:0]         pins_s;
  wire               cs_n_s;
  wire               sck_s;
  wire               si_s;
  reg                cs_n_d_ff;
  reg                sck_d_ff;
  reg  [6:0]         state_ff;
  reg  [6:0]         nxt_state;
  reg  [2:0]         bit_cnt_ff;
  reg  [7:0]         sr_ff;
  reg  [7:0]         op_ff;
  reg  [1:0]         acnt_ff;
  reg  [`ADDR_W-1:0] addr_ff;
  reg  [`ADDR_W-1:0] seq_addr_ff;
  reg  [`CNT_W-1:0]  dcnt_ff;
  reg  [2:0]         out_cnt_ff;
  reg  [7:0]         out_sr_ff;
  reg  [7:0]         src_byte;

  // Opcode class lookup, used for the fresh opcode and the held one
  function [4:0] op_class;
    input [7:0] op;
    begin
      case (op)
        `OP_READ_FAST:  op_class = `CLS_RD_FAST;
        `OP_READ_SLOW:  op_class = `CLS_RD_ADDR;
        `OP_READ_PROT:  op_class = `CLS_RD_ADDR;
        `OP_ERASE_4K,
        `OP_ERASE_32K,
        `OP_ERASE_64K:  op_class = `CLS_ADDR_ONLY;
        `OP_CHIP_ER_A,
        `OP_CHIP_ER_B:  op_class = `CLS_BARE;
        `OP_PROG_PAGE,
        `OP_PROG_SEQ_A,
        `OP_PROG_SEQ_B: op_class = `CLS_ADDR_DIN;
        `OP_PROT_SECT,
        `OP_UNPROT_SEC: op_class = `CLS_ADDR_ONLY;
        `OP_WRITE_EN,
        `OP_WRITE_DIS:  op_class = `CLS_BARE;
        `OP_WRITE_STAT: op_class = `CLS_DIN_ONLY;
        `OP_READ_STAT:  op_class = `CLS_DOUT_ONLY;
        `OP_READ_ID:    op_class = `CLS_DOUT_ONLY;
        `OP_PWR_DOWN,
        `OP_PWR_RESUME: op_class = `CLS_BARE;
        default:        op_class = `CLS_INVALID;
      endcase
    end
  endfunction

  // Phase that follows the last header byte of a class
  function [6:0] body_state;
    input [4:0] cls;
    begin
      if (cls[`CL_DIN])
        body_state = ST_DIN;
      else if (cls[`CL_DOUT])
        body_state = ST_DOUT;
      else
        body_state = ST_DONE;
    end
  endfunction

  // Sequential program opcode test
  function is_seq;
    input [7:0] op;
    begin
      is_seq = (op == `OP_PROG_SEQ_A) || (op == `OP_PROG_SEQ_B);
    end
  endfunction

  // Every pin passes two flops; chip select resets to inactive
  pin_sync #(
    .WIDTH   (3),
    .RST_VAL (3'h4)
  ) u_pin_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .async_i   ({cs_n_i, sck_i, si_i}),
    .sync_o    (pins_s)
  );

  assign cs_n_s = pins_s[2];
  assign sck_s  = pins_s[1];
  assign si_s   = pins_s[0];

  // Edge detection on the synchronised link clock
  wire       cs_act    = ~cs_n_s;
  wire       cs_end    = cs_n_s & ~cs_n_d_ff;
  wire       sck_rise  = sck_s & ~sck_d_ff;
  wire       sck_fall  = ~sck_s & sck_d_ff;
  wire       take_in   = state_ff[0] | state_ff[1] | state_ff[2] | state_ff[3];
  wire [7:0] byte_in   = {sr_ff[6:0], si_s};
  wire       byte_done = cs_act & sck_rise & take_in & (bit_cnt_ff == 3'h7);
  wire [4:0] new_cls   = op_class(byte_in);
  wire [4:0] cur_cls   = op_class(op_ff);
  wire       seq_skip  = is_seq(byte_in) & seq_mode_o;
  wire       is_arr    = (op_ff == `OP_READ_FAST) || (op_ff == `OP_READ_SLOW);
  wire       last_addr = (acnt_ff == `ADDR_BYTES_M1);
  wire [`ADDR_W-1:0] addr_full = {addr_ff[`ADDR_W-9:0], byte_in};

  // Frame sequencing; releasing chip select always returns to opcode wait
  always @* begin
    nxt_state = state_ff;
    if (!cs_act) begin
      nxt_state = ST_OPC;
    end else begin
      case (state_ff)
        ST_OPC: begin
          if (byte_done) begin
            if (!new_cls[`CL_VALID])
              nxt_state = ST_IGN;
            else if (new_cls[`CL_ADDR] && !seq_skip)
              nxt_state = ST_ADDR;
            else
              nxt_state = body_state(new_cls);
          end
        end
        ST_ADDR: begin
          if (byte_done && last_addr) begin
            if (cur_cls[`CL_DUMMY])
              nxt_state = ST_DUMMY;
            else
              nxt_state = body_state(cur_cls);
          end
        end
        ST_DUMMY: begin
          if (byte_done)
            nxt_state = ST_DOUT;
        end
        ST_DIN:   nxt_state = ST_DIN;
        ST_DOUT:  nxt_state = ST_DOUT;
        ST_DONE:  nxt_state = ST_DONE;
        ST_IGN:   nxt_state = ST_IGN;
        default:  nxt_state = ST_OPC;
      endcase
    end
  end

  // Byte source for the output shifter
  always @* begin
    case (op_ff)
      `OP_READ_STAT: src_byte = status_i;
      `OP_READ_PROT: src_byte = prot_i;
      `OP_READ_ID: begin
        if (dcnt_ff >= `ID_BYTES)
          src_byte = 8'h00;
        else begin
          case (dcnt_ff[1:0])
            2'h0:    src_byte = ID_WORD[31:24];
            2'h1:    src_byte = ID_WORD[23:16];
            2'h2:    src_byte = ID_WORD[15:8];
            default: src_byte = ID_WORD[7:0];
          endcase
        end
      end
      default:       src_byte = mem_data_i;
    endcase
  end

  // Main datapath
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cs_n_d_ff   <= 1'b1;
      sck_d_ff    <= 1'b0;
      state_ff    <= ST_OPC;
      bit_cnt_ff  <= 3'h0;
      sr_ff       <= 8'h00;
      op_ff       <= 8'h00;
      acnt_ff     <= 2'h0;
      addr_ff     <= {`ADDR_W{1'b0}};
      seq_addr_ff <= {`ADDR_W{1'b0}};
      dcnt_ff     <= {`CNT_W{1'b0}};
      out_cnt_ff  <= 3'h0;
      out_sr_ff   <= 8'h00;
      so_o        <= 1'b0;
      so_oe_n_o   <= 1'b1;
      mem_addr_o  <= {`ADDR_W{1'b0}};
      mem_rd_o    <= 1'b0;
      cmd_stb_o   <= 1'b0;
      cmd_op_o    <= 8'h00;
      cmd_addr_o  <= {`ADDR_W{1'b0}};
      cmd_cnt_o   <= {`CNT_W{1'b0}};
      wr_stb_o    <= 1'b0;
      wr_data_o   <= 8'h00;
      wr_addr_o   <= {`ADDR_W{1'b0}};
      seq_mode_o  <= 1'b0;
    end else begin
      cs_n_d_ff <= cs_n_s;
      sck_d_ff  <= sck_s;
      state_ff  <= nxt_state;
      cmd_stb_o <= 1'b0;
      wr_stb_o  <= 1'b0;

      // Frame boundary clears counters and floats the output
      if (!cs_act) begin
        bit_cnt_ff <= 3'h0;
        acnt_ff    <= 2'h0;
        dcnt_ff    <= {`CNT_W{1'b0}};
        out_cnt_ff <= 3'h0;
        so_oe_n_o  <= 1'b1;
        mem_rd_o   <= 1'b0;
      end else if (sck_rise && take_in) begin
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
        sr_ff      <= byte_in;
      end

      // Completed input bytes
      if (byte_done) begin
        case (state_ff)
          ST_OPC: begin
            op_ff   <= byte_in;
            acnt_ff <= 2'h0;
            if (seq_skip)
              addr_ff <= seq_addr_ff;
          end
          ST_ADDR: begin
            acnt_ff <= acnt_ff + 2'h1;
            addr_ff <= addr_full;
            if (last_addr) begin
              mem_addr_o <= addr_full;
              mem_rd_o   <= is_arr;
            end
          end
          ST_DIN: begin
            if (dcnt_ff != `PAGE_BYTES)
              dcnt_ff <= dcnt_ff + 9'h001;
            wr_stb_o  <= 1'b1;
            wr_data_o <= byte_in;
            // Page program wraps within its page; sequential reuses one address
            if (op_ff == `OP_PROG_PAGE)
              wr_addr_o <= {addr_ff[`ADDR_W-1:8], addr_ff[7:0] + dcnt_ff[7:0]};
            else
              wr_addr_o <= addr_ff;
          end
          default: begin
            acnt_ff <= acnt_ff;
          end
        endcase
      end

      // Output bytes shift out on falling edges, MSB first
      if (cs_act && sck_fall && (state_ff == ST_DOUT)) begin
        so_oe_n_o  <= 1'b0;
        out_cnt_ff <= out_cnt_ff + 3'h1;
        if (out_cnt_ff == 3'h0) begin
          so_o      <= src_byte[7];
          out_sr_ff <= {src_byte[6:0], 1'b0};
          if (dcnt_ff != `PAGE_BYTES)
            dcnt_ff <= dcnt_ff + 9'h001;
          // Advance early so the next byte is settled eight falling edges later
          if (is_arr)
            mem_addr_o <= mem_addr_o + 20'h0_0001;
        end else begin
          so_o      <= out_sr_ff[7];
          out_sr_ff <= {out_sr_ff[6:0], 1'b0};
        end
      end

      // Commit at chip select release only for complete frames
      if (cs_end) begin
        if (state_ff == ST_DONE) begin
          cmd_stb_o  <= 1'b1;
          cmd_op_o   <= op_ff;
          cmd_addr_o <= addr_ff;
          cmd_cnt_o  <= {`CNT_W{1'b0}};
          if (op_ff == `OP_WRITE_DIS)
            seq_mode_o <= 1'b0;
        end else if ((state_ff == ST_DIN) && (bit_cnt_ff == 3'h0) &&
                     (dcnt_ff != {`CNT_W{1'b0}}) &&
                     ((op_ff != `OP_WRITE_STAT) || (dcnt_ff == 9'h001))) begin
          cmd_stb_o  <= 1'b1;
          cmd_op_o   <= op_ff;
          cmd_addr_o <= addr_ff;
          cmd_cnt_o  <= dcnt_ff;
          if (is_seq(op_ff)) begin
            seq_mode_o  <= 1'b1;
            seq_addr_ff <= addr_ff + 20'h0_0001;
          end
        end
      end
    end
  end

endmodule
`default_nettype wire
